// >>> inc/dma_status_pkg.sv
// Package with register map, field layout and carrier types for the channel address/count/status block.
package dma_status_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          NUM_CH           = 8;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 16;
    localparam int          COUNT_W          = 10;
    localparam logic [7:0]  OFF_CH_BASE      = 8'h00;
    localparam logic [7:0]  OFF_COLLISION    = 8'h10;
    localparam logic [7:0]  OFF_ACTIVITY     = 8'h11;
    localparam logic [7:0]  OFF_RECENT_ADDR  = 8'h12;
    localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h13;
    localparam logic [7:0]  OFF_IRQ_MASK     = 8'h14;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          PERIPH_COLL_LSB  = 8;
    localparam int          LAST_CH_LSB      = 8;
    localparam logic [3:0]  LAST_CH_RESET    = 4'hf;
    localparam logic [15:0] PAD_RESET        = 16'h0000;
    localparam logic [9:0]  COUNT_RESET      = 10'h000;
    localparam int          IRQ_BLOCK_BIT    = 0;
    localparam int          IRQ_COLL_BIT     = 1;
    localparam int          IRQ_W            = 2;

    typedef enum logic [1:0]
    {
        MODE_CONT       = 2'h0,
        MODE_ONESHOT    = 2'h1,
        MODE_CONT_PP    = 2'h2,
        MODE_ONESHOT_PP = 2'h3
    } chan_mode_e;

    // One transfer beat reported by the channel engine.
    typedef struct packed
    {
        logic        valid;
        logic [2:0]  chan;
        logic [15:0] ram_addr;
    } xfer_beat_s;

    // Register port request.
    typedef struct packed
    {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

endpackage : dma_status_pkg

// >>> design/dma_channel_status.sv
// Channel peripheral address, transfer count and controller status block.
// ------------------------------------------------------------
// How it works
// - Each channel holds a 16-bit read/write peripheral address, zero at reset.
// - Ten-bit count per channel; a block is count plus one transfers.
// - Count bits 15 to 10 ignore writes and read zero.
// - Peripheral write-collision flags per channel at bits 15 down to 8.
// - DMA RAM write-collision flags per channel at bits 7 down to 0.
// - RAM collision is same-address same-cycle writes; any collision raises a trap.
// - Last active channel at bits 11 to 8, read-only, resets to all ones.
// - Each transfer loads the channel number 0 to 7; codes 8 to 14 never appear.
// - Read-only ping-pong bit per channel; one selects the secondary buffer.
// - Read-only register holding the most recent DMA RAM address, zero at reset.
// - Top four bits of the activity status read zero; writes have no effect.
// - Mode 10 continuous ping-pong, 11 one-shot ping-pong, 01 one-shot, 00 continuous.
// ------------------------------------------------------------
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns

module dma_channel_status
    import dma_status_pkg::*;
#(
    parameter int N_CH = NUM_CH                          // Number of channels.
)
(
    input  wire logic                  i_sys_clk,        // System clock, 10 MHz.
    input  wire logic                  i_srst,           // Synchronous reset, active high.
    input  wire logic [ADDR_W-1:0]     i_addr,           // Register address.
    input  wire logic [DATA_W-1:0]     i_wdata,          // Register write data.
    input  wire logic                  i_wr,             // Register write strobe.
    input  wire logic                  i_rd,             // Register read strobe.
    output logic      [DATA_W-1:0]     o_rdata,          // Read data, one cycle after the strobe.
    input  wire logic [N_CH-1:0]       i_channel_enable, // Per-channel enable from channel control.
    input  wire logic [2*N_CH-1:0]     i_mode,           // Two mode bits per channel.
    input  wire xfer_beat_s            i_beat,           // Transfer beat from the channel engine.
    input  wire logic                  i_beat_ram_wr,    // The beat writes DMA RAM.
    input  wire logic                  i_cpu_ram_wr,     // CPU writes DMA RAM this cycle.
    input  wire logic [15:0]           i_cpu_ram_addr,   // CPU DMA RAM write address.
    input  wire logic [N_CH-1:0]       i_periph_coll,    // Per-channel peripheral write collision.
    output logic      [N_CH*16-1:0]    o_periph_addr,    // Peripheral address per channel.
    output logic      [N_CH-1:0]       o_block_done,     // Pulse: block completed on channel.
    output logic      [N_CH-1:0]       o_pingpong_sel,   // Ping-pong buffer select per channel.
    output logic                       o_trap,           // Collision error trap, level.
    output logic                       o_irq             // Interrupt, level.
);

    // ------------------------------------------------------------
    // Channel storage
    // ------------------------------------------------------------
    logic [15:0]        periph_addr [N_CH];
    logic [COUNT_W-1:0] xfer_count  [N_CH];
    logic [COUNT_W-1:0] beat_count  [N_CH];
    logic [N_CH-1:0]    periph_wr_collision;
    logic [N_CH-1:0]    ram_wr_collision;
    logic [3:0]         last_active_channel;
    logic [N_CH-1:0]    pingpong_buffer_sel;
    logic [15:0]        recent_ram_addr;
    logic [IRQ_W-1:0]   irq_status;
    logic [IRQ_W-1:0]   irq_mask;
    logic [N_CH-1:0]    next_block_done;
    logic [N_CH-1:0]    ram_coll_now;
    logic               is_ch_reg;
    logic [2:0]         reg_ch;
    logic               reg_is_count;

    assign is_ch_reg    = (i_addr < (OFF_CH_BASE + 8'(2 * N_CH)));
    assign reg_ch       = i_addr[3:1];
    assign reg_is_count = i_addr[0];

    genvar g;
    generate
        for (g = 0; g < N_CH; g++)
        begin : g_ch
            assign o_periph_addr[g*16 +: 16] = periph_addr[g];
            assign next_block_done[g] = i_beat.valid && (i_beat.chan == 3'(g))
                                        && (beat_count[g] == xfer_count[g]);
            assign ram_coll_now[g] = i_beat.valid && (i_beat.chan == 3'(g)) && i_beat_ram_wr
                                     && i_cpu_ram_wr && (i_cpu_ram_addr == i_beat.ram_addr);
        end
    endgenerate

    // ------------------------------------------------------------
    // Address and count registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        for (int c = 0; c < N_CH; c++)
        begin
            if (i_srst)
            begin
                periph_addr[c] <= PAD_RESET;
                xfer_count[c]  <= COUNT_RESET;
            end
            else if (i_wr && is_ch_reg && reg_ch == 3'(c))
            begin
                if (reg_is_count)
                    xfer_count[c] <= i_wdata[COUNT_W-1:0];
                else
                    periph_addr[c] <= i_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Block progress and ping-pong selection
    // ------------------------------------------------------------
    // Beat counters restart when the channel is off so a new enable starts a clean block.
    always_ff @(posedge i_sys_clk)
    begin
        for (int c = 0; c < N_CH; c++)
        begin
            if (i_srst || !i_channel_enable[c])
                beat_count[c] <= '0;
            else if (next_block_done[c])
                beat_count[c] <= '0;
            else if (i_beat.valid && i_beat.chan == 3'(c))
                beat_count[c] <= beat_count[c] + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        for (int c = 0; c < N_CH; c++)
        begin
            if (i_srst)
                pingpong_buffer_sel[c] <= 1'b0;
            else if (!i_mode[2*c+1])
                pingpong_buffer_sel[c] <= 1'b0;
            else if (next_block_done[c])
                pingpong_buffer_sel[c] <= ~pingpong_buffer_sel[c];
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            o_block_done <= '0;
        else
            o_block_done <= next_block_done;
    end

    assign o_pingpong_sel = pingpong_buffer_sel;

    // ------------------------------------------------------------
    // Last channel and recent RAM address
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            last_active_channel <= LAST_CH_RESET;
            recent_ram_addr     <= 16'h0000;
        end
        else if (i_beat.valid)
        begin
            last_active_channel <= {1'b0, i_beat.chan};
            recent_ram_addr     <= i_beat.ram_addr;
        end
    end

    // ------------------------------------------------------------
    // Collision flags
    // ------------------------------------------------------------
    // A software write of zero clears a flag; a set in the same cycle survives.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            periph_wr_collision <= '0;
            ram_wr_collision    <= '0;
        end
        else if (i_wr && i_addr == OFF_COLLISION)
        begin
            periph_wr_collision <= (periph_wr_collision & i_wdata[PERIPH_COLL_LSB +: N_CH])
                                   | i_periph_coll;
            ram_wr_collision    <= (ram_wr_collision & i_wdata[N_CH-1:0]) | ram_coll_now;
        end
        else
        begin
            periph_wr_collision <= periph_wr_collision | i_periph_coll;
            ram_wr_collision    <= ram_wr_collision | ram_coll_now;
        end
    end

    assign o_trap = |{periph_wr_collision, ram_wr_collision};

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_event;
    assign irq_event[IRQ_BLOCK_BIT] = |next_block_done;
    assign irq_event[IRQ_COLL_BIT]  = |{i_periph_coll, ram_coll_now};

    // A status read that meets a new event clears and sets again at once, so no event is lost.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            irq_status <= '0;
        else if (i_rd && i_addr == OFF_IRQ_STATUS)
            irq_status <= irq_event;
        else
            irq_status <= irq_status | irq_event;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            irq_mask <= '0;
        else if (i_wr && i_addr == OFF_IRQ_MASK)
            irq_mask <= i_wdata[IRQ_W-1:0];
    end

    assign o_irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read data stand for one cycle only; idle cycles return zero so stale data never look fresh.
    logic [DATA_W-1:0] next_rdata;

    always_comb
    begin
        next_rdata = '0;
        if (is_ch_reg)
            next_rdata = reg_is_count ? {6'h00, xfer_count[reg_ch]} : periph_addr[reg_ch];
        else
        begin
            case (i_addr)
                OFF_COLLISION:   next_rdata = {periph_wr_collision, ram_wr_collision};
                OFF_ACTIVITY:    next_rdata = {4'h0, last_active_channel, pingpong_buffer_sel};
                OFF_RECENT_ADDR: next_rdata = recent_ram_addr;
                OFF_IRQ_STATUS:  next_rdata = {14'h0000, irq_status};
                OFF_IRQ_MASK:    next_rdata = {14'h0000, irq_mask};
                default:         next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            o_rdata <= '0;
        else if (i_rd)
            o_rdata <= next_rdata;
        else
            o_rdata <= '0;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_beat_on(int c);
        i_beat.valid && i_beat.chan == 3'(c);
    endsequence

    // A block end in a ping-pong mode is the step that must flip the buffer select.
    sequence s_pp_block_end(int c);
        next_block_done[c] && i_mode[2*c+1];
    endsequence

    a_last_ch_reserved: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        last_active_channel[3] |-> last_active_channel == LAST_CH_RESET)
        else $error("last channel holds a reserved code");

    a_last_ch_tracks: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_beat.valid |=> last_active_channel == {1'b0, $past(i_beat.chan)})
        else $error("last channel not updated");

    a_recent_addr_load: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_beat.valid |=> recent_ram_addr == $past(i_beat.ram_addr))
        else $error("recent address not updated");

    a_recent_readonly: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_wr && i_addr == OFF_RECENT_ADDR && !i_beat.valid |=> recent_ram_addr == $past(recent_ram_addr))
        else $error("recent address changed by a write");

    a_count_upper_zero: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_rd && is_ch_reg && reg_is_count |=> o_rdata[15:10] == 6'h00)
        else $error("count upper bits not zero");

    a_activity_top_zero: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_rd && i_addr == OFF_ACTIVITY |=> o_rdata[15:12] == 4'h0)
        else $error("activity status top bits not zero");

    a_pad_write: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_wr && i_addr == 8'h00 |=> periph_addr[0] == $past(i_wdata))
        else $error("peripheral address write lost");

    // Per-channel checks, so whichever channel a scenario happens to pick is covered.
    generate
        for (g = 0; g < N_CH; g++)
        begin : g_chk
            a_coll_set_wins: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                ram_coll_now[g] |=> ram_wr_collision[g])
                else $error("ram collision flag lost");

            a_coll_clear: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                i_wr && i_addr == OFF_COLLISION && !i_wdata[g] && !ram_coll_now[g] |=> !ram_wr_collision[g])
                else $error("ram collision flag not cleared");

            a_pcoll_sticky: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                periph_wr_collision[g] && !(i_wr && i_addr == OFF_COLLISION) |=> periph_wr_collision[g])
                else $error("peripheral collision flag dropped");

            a_rcoll_sticky: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                ram_wr_collision[g] && !(i_wr && i_addr == OFF_COLLISION) |=> ram_wr_collision[g])
                else $error("ram collision flag dropped");

            a_trap_follows: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                i_periph_coll[g] |=> o_trap)
                else $error("trap not raised on collision");

            a_trap_ram: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                ram_coll_now[g] |=> o_trap)
                else $error("trap not raised on ram collision");

            a_done_pulse: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                next_block_done[g] |=> o_block_done[g])
                else $error("block done pulse missing");

            a_beat_restart: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                !i_channel_enable[g] |=> beat_count[g] == '0)
                else $error("beat counter not restarted");

            a_count_write: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                i_wr && is_ch_reg && reg_is_count && reg_ch == 3'(g)
                    |=> xfer_count[g] == $past(i_wdata[COUNT_W-1:0]))
                else $error("transfer count write lost");

            a_pp_zero_nonpp: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                !i_mode[2*g+1] |=> !pingpong_buffer_sel[g])
                else $error("ping-pong bit set outside ping-pong mode");

            a_pp_toggle: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                s_beat_on(g) ##0 s_pp_block_end(g) |=> pingpong_buffer_sel[g] != $past(pingpong_buffer_sel[g]))
                else $error("ping-pong bit did not toggle");

            a_pp_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                i_mode[2*g+1] && !next_block_done[g] |=> pingpong_buffer_sel[g] == $past(pingpong_buffer_sel[g]))
                else $error("ping-pong bit moved without a block end");
        end
    endgenerate

endmodule : dma_channel_status

// >>> tb/engine_model.sv
// Behavioural channel engine and CPU sharing DMA RAM, feeding transfer beats to the status block.
`timescale 1ns/1ns
module engine_model
    import dma_status_pkg::*;
(
    input  wire logic        i_sys_clk,  // System clock.
    input  wire logic        i_srst,     // Synchronous reset.
    input  wire logic        i_start,    // Start a run of beats.
    input  wire logic [2:0]  i_chan,     // Channel of the run.
    input  wire logic [11:0] i_beats,    // Beats in the run.
    input  wire logic [15:0] i_base,     // First DMA RAM address.
    input  wire logic        i_cpu_hit,  // CPU writes the first beat's address.
    output logic      [7:0]  o_enable,   // Channel enables.
    output xfer_beat_s       o_beat,     // Beat towards the block.
    output logic             o_ram_wr,   // Beat writes DMA RAM.
    output logic             o_cpu_wr,   // CPU DMA RAM write.
    output logic      [15:0] o_cpu_addr, // CPU write address.
    output logic             o_busy      // Run in progress.
);
    logic [11:0] left;
    logic [11:0] k;

    // Idle address lines show the inverse of their last value, so stale data never looks valid.
    always_ff @(posedge i_sys_clk)
    begin
        o_beat.valid <= 1'b0;
        o_cpu_wr     <= 1'b0;
        o_cpu_addr   <= ~o_cpu_addr;
        o_beat.ram_addr <= ~o_beat.ram_addr;
        if (i_srst)
        begin
            o_busy   <= 1'b0;
            o_enable <= 8'h00;
            o_ram_wr <= 1'b0;
            // Inverting an unknown stays unknown, so the idle lines start from a known value.
            o_beat.chan     <= 3'h0;
            o_beat.ram_addr <= 16'h0000;
            o_cpu_addr      <= 16'h0000;
        end
        else if (i_start)
        begin
            o_busy   <= 1'b1;
            left     <= i_beats;
            k        <= 12'h000;
            o_enable <= 8'h01 << i_chan;
        end
        else if (o_busy && left != 12'h000)
        begin
            o_beat.valid    <= 1'b1;
            o_beat.chan     <= i_chan;
            o_beat.ram_addr <= i_base + 16'(k);
            o_ram_wr        <= 1'b1;
            o_cpu_wr        <= (k == 12'h000);
            o_cpu_addr      <= i_cpu_hit ? i_base : i_base + 16'h0001;
            left            <= left - 12'h001;
            k               <= k + 12'h001;
        end
        else
        begin
            o_busy   <= 1'b0;
            o_enable <= 8'h00;
        end
    end
endmodule : engine_model

// >>> tb/dma_channel_status_test.sv
// Self-checking bench for the channel address, count and status block.
`timescale 1ns/1ns
module dma_channel_status_test;
    import dma_status_pkg::*;
    logic               sys_clk;
    logic               srst = 1'b1;
    logic [7:0]         addr = 8'h00;
    logic [15:0]        wdata = 16'h0000;
    logic               wr = 1'b0;
    logic               rd = 1'b0;
    logic [15:0]        mode = 16'h0000;
    logic [7:0]         pcoll = 8'h00;
    logic               start = 1'b0;
    logic [2:0]         chan = 3'h0;
    logic [11:0]        beats = 12'h000;
    logic [15:0]        base = 16'h0000;
    logic               hit = 1'b0;
    logic [15:0]        rdata, cpu_addr;
    logic [127:0]       paddr;
    logic [7:0]         done, pp, en;
    logic               trap, irq, ram_wr, cpu_wr, busy;
    xfer_beat_s         beat;
    int                 n_mismatch = 0;
    int                 tests_run = 0;
    int                 n_done;

    dma_channel_status i_dut (.i_sys_clk(sys_clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_channel_enable(en), .i_mode(mode), .i_beat(beat), .i_beat_ram_wr(ram_wr),
        .i_cpu_ram_wr(cpu_wr), .i_cpu_ram_addr(cpu_addr), .i_periph_coll(pcoll), .o_periph_addr(paddr),
        .o_block_done(done), .o_pingpong_sel(pp), .o_trap(trap), .o_irq(irq));
    engine_model i_eng (.i_sys_clk(sys_clk), .i_srst(srst), .i_start(start), .i_chan(chan), .i_beats(beats),
        .i_base(base), .i_cpu_hit(hit), .o_enable(en), .o_beat(beat), .o_ram_wr(ram_wr), .o_cpu_wr(cpu_wr),
        .o_cpu_addr(cpu_addr), .o_busy(busy));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always_ff @(posedge sys_clk) n_done <= srst ? 0 : n_done + $countones(done);

    // ------------------------------------------------------------
    // Bus cycles, comparison and closing
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
        pcoll <= 8'h00;
        @(posedge sys_clk);
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so they are sampled just past that edge.
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1 v = rdata;
        check(v, exp);
        @(posedge sys_clk);
    endtask : rd_chk

    task automatic run(input logic [2:0] c, input logic [11:0] n, input logic [15:0] b, input logic h);
        int t;
        chan  <= c;
        beats <= n;
        base  <= b;
        hit   <= h;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        for (t = 0; t < 4000; t++)
        begin
            @(posedge sys_clk);
            #1 if (!busy) break;
        end
        if (busy)
        begin
            n_mismatch++;
            finish_test();
        end
        repeat (3) @(posedge sys_clk);
    endtask : run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        logic [15:0] pad[8];
        logic [15:0] cw[8];
        logic [15:0] k, b;
        int c, m, d0;
        void'($urandom(32'h16fc));
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        for (c = 0; c < 8; c++)
        begin
            rd_chk(8'(2*c), PAD_RESET);
            rd_chk(8'(2*c+1), 16'h0000);
        end
        rd_chk(OFF_COLLISION, 16'h0000);
        rd_chk(OFF_ACTIVITY, {4'h0, LAST_CH_RESET, 8'h00});
        rd_chk(OFF_RECENT_ADDR, 16'h0000);
        for (c = 0; c < 8; c++)
        begin
            pad[c] = 16'($urandom);
            cw[c] = (c == 7) ? 16'hffff : 16'($urandom);
            wr_reg(8'(2*c), pad[c]);
            wr_reg(8'(2*c+1), cw[c]);
        end
        for (c = 0; c < 8; c++)
        begin
            rd_chk(8'(2*c), pad[c]);
            rd_chk(8'(2*c+1), cw[c] & 16'h03ff);
            check(paddr[16*c+:16], pad[c]);
        end
        wr_reg(OFF_ACTIVITY, 16'hffff);
        wr_reg(OFF_RECENT_ADDR, 16'hffff);
        wr_reg(8'h20, 16'hffff);
        rd_chk(OFF_ACTIVITY, {4'h0, LAST_CH_RESET, 8'h00});
        rd_chk(OFF_RECENT_ADDR, 16'h0000);
        rd_chk(8'h20, 16'h0000);
        wr_reg(OFF_IRQ_MASK, 16'h0001);
        for (m = 0; m < 4; m++)
        begin
            c = $urandom_range(7);
            k = (m == 0) ? 16'h0000 : 16'($urandom_range(5));
            b = 16'($urandom);
            wr_reg(8'(2*c+1), k);
            mode <= 16'(m) << (2*c);
            d0 = n_done;
            run(3'(c), 12'(3*(k+1)), b, 1'b0);
            check(16'(n_done - d0), 16'h0003);
            check({8'h00, pp}, 16'(m[1]) << c);
            rd_chk(OFF_ACTIVITY, {5'h00, 3'(c), 8'(m[1]) << c});
            rd_chk(OFF_RECENT_ADDR, b + 16'(3*(k+1)-1));
            mode <= 16'h0000;
            @(posedge sys_clk);
        end
        check({15'h0000, irq}, 16'h0001);
        rd_chk(OFF_IRQ_STATUS, 16'h0001);
        rd_chk(OFF_IRQ_STATUS, 16'h0000);
        check({15'h0000, irq}, 16'h0000);
        wr_reg(OFF_IRQ_MASK, 16'h0002);
        c = $urandom_range(7);
        pcoll <= 8'h01 << c;
        @(posedge sys_clk);
        pcoll <= 8'h00;
        run(3'(c), 12'd2, b, 1'b0);
        run(3'(7-c), 12'd2, b, 1'b1);
        rd_chk(OFF_COLLISION, {8'h01 << c, 8'h01 << (7-c)});
        check({15'h0000, trap}, 16'h0001);
        check({15'h0000, irq}, 16'h0001);
        wr_reg(OFF_COLLISION, 16'hffff);
        rd_chk(OFF_COLLISION, {8'h01 << c, 8'h01 << (7-c)});
        pcoll <= 8'h01 << c;
        wr_reg(OFF_COLLISION, 16'h0000);
        rd_chk(OFF_COLLISION, {8'h01 << c, 8'h00});
        wr_reg(OFF_COLLISION, 16'h0000);
        rd_chk(OFF_COLLISION, 16'h0000);
        check({15'h0000, trap}, 16'h0000);
        rd_chk(OFF_IRQ_MASK, 16'h0002);
        wr_reg(OFF_IRQ_STATUS, 16'h0000);
        addr <= OFF_IRQ_STATUS;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check({15'h0000, irq}, 16'h0000);
        finish_test();
    end
endmodule : dma_channel_status_test
